// >>> common/fsync_pkg.sv
package fsync_pkg;

    localparam int ADDR_W       = 9;
    localparam int DATA_W       = 16;
    localparam int CMD_BITS     = ADDR_W + 1 + DATA_W;
    localparam int EXPO_WORDS   = 5;
    localparam int ROI_SEL_W    = 8;
    localparam int LINES_W      = 8;

    localparam logic [ADDR_W-1:0] SEQ_CTRL_ADDR    = 9'h0C0;
    localparam logic [ADDR_W-1:0] ROI_SELECT_ADDR  = 9'h0C3;
    localparam logic [ADDR_W-1:0] BLACK_LINES_ADDR = 9'h0C5;
    localparam logic [ADDR_W-1:0] DUMMY_LINES_ADDR = 9'h0C6;
    localparam logic [ADDR_W-1:0] EXPO_FIRST_ADDR  = 9'h0C7;
    localparam logic [ADDR_W-1:0] EXPO_LAST_ADDR   = 9'h0CB;
    localparam logic [ADDR_W-1:0] GAIN_ADDR        = 9'h0CC;
    localparam logic [ADDR_W-1:0] FREEZE_CTRL_ADDR = 9'h0CE;
    localparam logic [ADDR_W-1:0] BLK_LEVEL_FIRST  = 9'h080;
    localparam logic [ADDR_W-1:0] BLK_LEVEL_LAST   = 9'h081;
    localparam logic [ADDR_W-1:0] SYNC_CODE_FIRST  = 9'h082;
    localparam logic [ADDR_W-1:0] SYNC_CODE_LAST   = 9'h087;
    localparam logic [ADDR_W-1:0] TEST_PAT_FIRST   = 9'h090;
    localparam logic [ADDR_W-1:0] TEST_PAT_LAST    = 9'h096;

    // Bit positions inside the sequencer control word
    localparam int SEQ_EN_BIT     = 0;
    localparam int ROLLING_BIT    = 1;
    localparam int TRIGGERED_BIT  = 4;
    localparam int SLAVE_BIT      = 5;
    localparam int SUBSAMPLE_BIT  = 7;
    localparam int BINNING_BIT    = 8;
    localparam int EXPO_SAME_BIT  = 9;
    // Other field positions
    localparam int BLACK_LVL_BIT  = 8;
    localparam int SYNC_CODE_BIT  = 13;
    localparam int GAIN_ALIGN_BIT = 13;
    localparam int FRZ_XLEN_BIT   = 0;
    localparam int FRZ_BLACK_BIT  = 1;
    localparam int FRZ_DUMMY_BIT  = 2;
    localparam int FRZ_EXPO_BIT   = 3;
    localparam int FRZ_GAIN_BIT   = 4;
    localparam int FRZ_ROI_BIT    = 5;
    localparam int BLANK_ROI_BIT  = 8;
    localparam int STAT_BLANK_BIT = 15;
    localparam int STAT_ARTF_BIT  = 14;

    localparam logic [DATA_W-1:0] SEQ_CTRL_RST    = 16'h0000;
    localparam logic [DATA_W-1:0] FREEZE_CTRL_RST = 16'h003F;
    localparam logic [DATA_W-1:0] FREEZE_WR_MASK  = 16'h013F;
    localparam logic [DATA_W-1:0] ROI_SELECT_RST  = 16'h0001;
    localparam logic [DATA_W-1:0] BLACK_LINES_RST = 16'h0008;
    localparam logic [DATA_W-1:0] DUMMY_LINES_RST = 16'h0000;
    localparam logic [DATA_W-1:0] GAIN_RST        = 16'h0000;
    localparam logic [DATA_W-1:0] EXPO_WORD_RST   = 16'h0000;
    localparam int TRANSIENT_FRAMES = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cfg_write_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } spi_pins_t;

    typedef struct packed {
        logic [ROI_SEL_W-1:0]         roi_select;
        logic                         subsample;
        logic                         binning;
        logic [DATA_W-1:0]            black_lines;
        logic [DATA_W-1:0]            dummy_lines;
        logic [EXPO_WORDS*DATA_W-1:0] exposure;
        logic [DATA_W-1:0]            gain;
    } active_cfg_t;

endpackage

// >>> rtl/cfg_serial_port.sv
`timescale 1ns/100ps
module cfg_serial_port
    import fsync_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire spi_pins_t         pins_i,
    output logic                   miso_o,
    output logic                   miso_oe_o,
    output logic      [ADDR_W-1:0] rd_addr_o,
    input  wire logic [DATA_W-1:0] rd_data_i,
    output logic                   wr_valid_o,
    output cfg_write_t             wr_o
);
    // Index 0 is the metastable stage; only index 1 and above feed the logic
    logic [2:0]          sck_q;
    logic [1:0]          cs_q;
    logic [1:0]          mosi_q;
    logic [4:0]          bit_cnt_q;
    logic [CMD_BITS-2:0] shift_in_q;
    logic [DATA_W-1:0]   shift_out_q;
    logic                reading_q;
    logic                wr_valid_q;
    cfg_write_t          wr_q;
    logic                selected;
    logic                sck_rise;
    logic                sck_fall;
    logic [CMD_BITS-1:0] full_word;
    logic                last_bit;
    logic                addr_done;

    assign selected  = ~cs_q[1];
    assign sck_rise  = sck_q[1] & ~sck_q[2];
    assign sck_fall  = ~sck_q[1] & sck_q[2];
    assign full_word = {shift_in_q, mosi_q[1]};
    assign last_bit  = sck_rise & (bit_cnt_q == 5'(CMD_BITS - 1));
    assign addr_done = bit_cnt_q == 5'(ADDR_W + 1);
    assign rd_addr_o = shift_in_q[ADDR_W:1];
    assign miso_o    = shift_out_q[DATA_W-1];
    assign miso_oe_o = reading_q;
    assign wr_valid_o = wr_valid_q;
    assign wr_o      = wr_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sck_q  <= 3'h0;
            cs_q   <= 2'h3;
            mosi_q <= 2'h0;
        end else begin
            sck_q  <= {sck_q[1:0], pins_i.sck};
            cs_q   <= {cs_q[0], pins_i.cs_n};
            mosi_q <= {mosi_q[0], pins_i.mosi};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !selected) begin
            bit_cnt_q   <= 5'h00;
            shift_in_q  <= '0;
            shift_out_q <= '0;
            reading_q   <= 1'b0;
        end else begin
            if (sck_rise) begin
                shift_in_q <= full_word[CMD_BITS-2:0];
                bit_cnt_q  <= bit_cnt_q + 5'h01;
            end
            // Read data is fetched once the address and direction are known
            if (sck_fall && addr_done && !shift_in_q[0]) begin
                shift_out_q <= rd_data_i;
                reading_q   <= 1'b1;
            end else if (sck_fall && reading_q) begin
                shift_out_q <= {shift_out_q[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wr_valid_q <= 1'b0;
            wr_q       <= '0;
        end else begin
            wr_valid_q <= selected & last_bit & full_word[DATA_W];
            if (selected && last_bit) begin
                wr_q.addr <= full_word[CMD_BITS-1:DATA_W+1];
                wr_q.data <= full_word[DATA_W-1:0];
            end
        end
    end

endmodule

// >>> rtl/frame_sync_config_update.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Running frame keeps its starting parameters
// - Subsampling and binning change at frame start
// - Line count change blanks one rolling frame
// - Blanked frame sends training patterns, no image
// - Rolling window switch blanks one frame optionally
// - Only a new selection counts as switch
// - Exposure one frame late, except triggered global master with the same-frame exposure bit set
// - Gain applies at next frame start
// - Gain delay-align adds one more frame
// - Black-level changes give transient bad frames
// - Sync code write corrupts codes that frame
// - Test pattern change corrupts ARTIFACT_FRAMES frames, like black level
// - Acquisition continues; new setting applies afterwards
// - Freeze bits live in one serial register
// - Released group transfers writes at frame boundaries
// - Re-release refreshes active set from written values
// - Frozen writes become active one frame after release
// - Frozen group holds writes in shadow, keeps old active values
// - Window freeze covers selection, subsample, binning only
module frame_sync_config_update
    import fsync_pkg::*;
#(
    parameter int ARTIFACT_FRAMES = TRANSIENT_FRAMES
) (
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  spi_sck_i,
    input  wire logic  spi_cs_n_i,
    input  wire logic  spi_mosi_i,
    output logic       spi_miso_o,
    output logic       spi_miso_oe_o,
    input  wire logic  frame_start_i,
    output logic       seq_enable_o,
    output logic       rolling_shutter_o,
    output logic       triggered_mode_o,
    output logic       slave_mode_o,
    output active_cfg_t active_cfg_o,
    output logic       blank_frame_o,
    output logic       training_pattern_o,
    output logic       image_enable_o,
    output logic       artifact_frame_o
);
    initial begin
        if (ARTIFACT_FRAMES < 1 || ARTIFACT_FRAMES > 15)
            $error("frame_sync_config_update: ARTIFACT_FRAMES out of 1..15");
    end

    localparam int EXPO_W = EXPO_WORDS * DATA_W;
    localparam int ROI_W  = ROI_SEL_W + 2;
    localparam logic [ROI_W-1:0] ROI_RST = {ROI_SELECT_RST[ROI_SEL_W-1:0], 2'b00};
    localparam logic [3:0] ARTF_LOAD = 4'(ARTIFACT_FRAMES);

    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Serial configuration port
    spi_pins_t         pins;
    cfg_write_t        wr;
    logic              wr_valid;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;

    assign pins = '{sck: spi_sck_i, cs_n: spi_cs_n_i, mosi: spi_mosi_i};

    cfg_serial_port u_port (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .pins_i     (pins),
        .miso_o     (spi_miso_o),
        .miso_oe_o  (spi_miso_oe_o),
        .rd_addr_o  (rd_addr),
        .rd_data_i  (rd_data),
        .wr_valid_o (wr_valid),
        .wr_o       (wr)
    );

    // Write decode
    logic hit_seq;
    logic hit_roi;
    logic hit_black;
    logic hit_dummy;
    logic hit_expo;
    logic hit_gain;
    logic hit_freeze;
    logic hit_blk_level;
    logic hit_sync_code;
    logic hit_test_pat;

    assign hit_seq       = wr_valid & (wr.addr == SEQ_CTRL_ADDR);
    assign hit_roi       = wr_valid & (wr.addr == ROI_SELECT_ADDR);
    assign hit_black     = wr_valid & (wr.addr == BLACK_LINES_ADDR);
    assign hit_dummy     = wr_valid & (wr.addr == DUMMY_LINES_ADDR);
    assign hit_expo      = wr_valid & in_range(wr.addr, EXPO_FIRST_ADDR, EXPO_LAST_ADDR);
    assign hit_gain      = wr_valid & (wr.addr == GAIN_ADDR);
    assign hit_freeze    = wr_valid & (wr.addr == FREEZE_CTRL_ADDR);
    assign hit_blk_level = wr_valid & in_range(wr.addr, BLK_LEVEL_FIRST, BLK_LEVEL_LAST);
    assign hit_sync_code = wr_valid & (in_range(wr.addr, SYNC_CODE_FIRST, SYNC_CODE_LAST)
                         | ((wr.addr == BLK_LEVEL_LAST) & wr.data[SYNC_CODE_BIT]));
    assign hit_test_pat  = wr_valid & in_range(wr.addr, TEST_PAT_FIRST, TEST_PAT_LAST);

    // Static mode word and freeze control word
    logic [DATA_W-1:0] seq_ctrl_q;
    logic [DATA_W-1:0] freeze_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            seq_ctrl_q <= SEQ_CTRL_RST;
            freeze_q   <= FREEZE_CTRL_RST;
        end else begin
            // Mode bits other than subsample and binning act at once; the host only changes them while stopped
            if (hit_seq) seq_ctrl_q <= wr.data;
            if (hit_freeze) freeze_q <= wr.data & FREEZE_WR_MASK;
        end
    end

    logic rolling;
    logic same_frame_expo;
    assign rolling         = seq_ctrl_q[ROLLING_BIT];
    assign same_frame_expo = seq_ctrl_q[TRIGGERED_BIT] & ~seq_ctrl_q[SLAVE_BIT]
                           & ~rolling & seq_ctrl_q[EXPO_SAME_BIT];

    // Window group: selection plus subsample and binning from the mode word
    logic [ROI_W-1:0] roi_next;
    logic [ROI_W-1:0] roi_shadow;
    logic [ROI_W-1:0] roi_active;
    logic             roi_update;
    logic             roi_wr;
    assign roi_wr   = hit_roi | hit_seq;
    assign roi_next = {hit_roi ? wr.data[ROI_SEL_W-1:0] : roi_shadow[ROI_W-1:2],
                       hit_seq ? wr.data[SUBSAMPLE_BIT] : roi_shadow[1],
                       hit_seq ? wr.data[BINNING_BIT]   : roi_shadow[0]};

    shadow_active_reg #(.WIDTH(ROI_W), .RESET(ROI_RST)) u_roi (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (roi_wr),
        .wr_data_i     (roi_next),
        .frame_start_i (frame_start_i),
        .sync_en_i     (freeze_q[FRZ_ROI_BIT]),
        .shadow_o      (roi_shadow),
        .active_o      (roi_active),
        .update_o      (roi_update)
    );

    // Line count groups
    logic [DATA_W-1:0] black_shadow;
    logic [DATA_W-1:0] black_active;
    logic              black_update;
    logic [DATA_W-1:0] dummy_shadow;
    logic [DATA_W-1:0] dummy_active;
    logic              dummy_update;
    shadow_active_reg #(.WIDTH(DATA_W), .RESET(BLACK_LINES_RST)) u_black (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (hit_black),
        .wr_data_i     (wr.data),
        .frame_start_i (frame_start_i),
        .sync_en_i     (freeze_q[FRZ_BLACK_BIT]),
        .shadow_o      (black_shadow),
        .active_o      (black_active),
        .update_o      (black_update)
    );

    shadow_active_reg #(.WIDTH(DATA_W), .RESET(DUMMY_LINES_RST)) u_dummy (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (hit_dummy),
        .wr_data_i     (wr.data),
        .frame_start_i (frame_start_i),
        .sync_en_i     (freeze_q[FRZ_DUMMY_BIT]),
        .shadow_o      (dummy_shadow),
        .active_o      (dummy_active),
        .update_o      (dummy_update)
    );

    // Exposure group: the words are replaced one at a time
    logic [EXPO_W-1:0] expo_next;
    logic [EXPO_W-1:0] expo_shadow;
    logic [EXPO_W-1:0] expo_active;
    logic [2:0]        expo_idx;
    assign expo_idx = 3'(wr.addr - EXPO_FIRST_ADDR);

    always_comb begin
        expo_next = expo_shadow;
        expo_next[expo_idx*DATA_W +: DATA_W] = wr.data;
    end

    shadow_active_reg #(.WIDTH(EXPO_W), .RESET({EXPO_WORDS{EXPO_WORD_RST}})) u_expo (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (hit_expo),
        .wr_data_i     (expo_next),
        .frame_start_i (frame_start_i),
        .sync_en_i     (freeze_q[FRZ_EXPO_BIT]),
        .shadow_o      (expo_shadow),
        .active_o      (expo_active),
        .update_o      ()
    );

    // Gain group
    logic [DATA_W-1:0] gain_shadow;
    logic [DATA_W-1:0] gain_active;
    shadow_active_reg #(.WIDTH(DATA_W), .RESET(GAIN_RST)) u_gain (
        .ref_clk_i     (ref_clk_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (hit_gain),
        .wr_data_i     (wr.data),
        .frame_start_i (frame_start_i),
        .sync_en_i     (freeze_q[FRZ_GAIN_BIT]),
        .shadow_o      (gain_shadow),
        .active_o      (gain_active),
        .update_o      ()
    );

    // Extra frame stage for exposure and for aligned gain
    logic [EXPO_W-1:0] expo_late_q;
    logic [DATA_W-1:0] gain_late_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            expo_late_q <= {EXPO_WORDS{EXPO_WORD_RST}};
            gain_late_q <= GAIN_RST;
        end else if (frame_start_i) begin
            expo_late_q <= expo_active;
            gain_late_q <= gain_active;
        end
    end

    logic [EXPO_W-1:0] expo_used;
    logic [DATA_W-1:0] gain_used;
    assign expo_used = same_frame_expo ? expo_active : expo_late_q;
    assign gain_used = gain_active[GAIN_ALIGN_BIT] ? gain_late_q : gain_active;

    // Blanking decision, taken for the frame that is starting
    logic black_moved;
    logic dummy_moved;
    logic window_switch;
    logic blank_req;
    logic blank_q;

    assign black_moved   = black_update & (black_shadow[LINES_W-1:0] != black_active[LINES_W-1:0]);
    assign dummy_moved   = dummy_update & (dummy_shadow != dummy_active);
    // Resizing the active window is not a switch; only a new selection is
    assign window_switch = roi_update & (roi_shadow[ROI_W-1:2] != roi_active[ROI_W-1:2]);
    assign blank_req     = rolling & (black_moved | dummy_moved
                         | (window_switch & freeze_q[BLANK_ROI_BIT]));

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            blank_q <= 1'b0;
        end else if (frame_start_i) begin
            blank_q <= blank_req;
        end
    end

    // Transient artifact tracking; acquisition never stops for these
    logic       blk_bit_moved;
    logic       pend_q;
    logic       pend_d;
    logic [3:0] artf_cnt_q;
    logic [3:0] artf_cnt_d;
    assign blk_bit_moved = black_update
                         & (black_shadow[BLACK_LVL_BIT] != black_active[BLACK_LVL_BIT]);
    // A write in the frame-start cycle stays pending: set wins over clear
    assign pend_d = hit_blk_level | hit_test_pat | (pend_q & ~frame_start_i);

    always_comb begin
        artf_cnt_d = artf_cnt_q;
        if (frame_start_i && (pend_q || blk_bit_moved)) begin
            artf_cnt_d = ARTF_LOAD;
        end else if (hit_sync_code && artf_cnt_q <= 4'h1) begin
            artf_cnt_d = 4'h1;
        end else if (frame_start_i && artf_cnt_q != 4'h0) begin
            artf_cnt_d = artf_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pend_q     <= 1'b0;
            artf_cnt_q <= 4'h0;
        end else begin
            pend_q     <= pend_d;
            artf_cnt_q <= artf_cnt_d;
        end
    end

    // Register read mux returns the written values; the freeze word also carries the blank and artifact status bits
    logic [DATA_W-1:0] status_bits;
    logic [2:0]        rd_idx;

    assign rd_idx      = 3'(rd_addr - EXPO_FIRST_ADDR);
    assign status_bits = {blank_q, artf_cnt_q != 4'h0, {(DATA_W-2){1'b0}}};

    always_comb begin
        rd_data = '0;
        if (rd_addr == SEQ_CTRL_ADDR) begin
            rd_data = seq_ctrl_q;
        end else if (rd_addr == ROI_SELECT_ADDR) begin
            rd_data = {{(DATA_W-ROI_SEL_W){1'b0}}, roi_shadow[ROI_W-1:2]};
        end else if (rd_addr == BLACK_LINES_ADDR) begin
            rd_data = black_shadow;
        end else if (rd_addr == DUMMY_LINES_ADDR) begin
            rd_data = dummy_shadow;
        end else if (in_range(rd_addr, EXPO_FIRST_ADDR, EXPO_LAST_ADDR)) begin
            rd_data = expo_shadow[rd_idx*DATA_W +: DATA_W];
        end else if (rd_addr == GAIN_ADDR) begin
            rd_data = gain_shadow;
        end else if (rd_addr == FREEZE_CTRL_ADDR) begin
            rd_data = freeze_q | status_bits;
        end
    end

    // Output registers
    active_cfg_t cfg_d;
    active_cfg_t cfg_q;
    logic        mode_en_q;
    logic        mode_roll_q;
    logic        mode_trig_q;
    logic        mode_slave_q;
    always_comb begin
        cfg_d             = '0;
        cfg_d.roi_select  = roi_active[ROI_W-1:2];
        cfg_d.subsample   = roi_active[1];
        cfg_d.binning     = roi_active[0];
        cfg_d.black_lines = black_active;
        cfg_d.dummy_lines = dummy_active;
        cfg_d.exposure    = expo_used;
        cfg_d.gain        = gain_used;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cfg_q        <= '0;
            mode_en_q    <= 1'b0;
            mode_roll_q  <= 1'b0;
            mode_trig_q  <= 1'b0;
            mode_slave_q <= 1'b0;
        end else begin
            cfg_q        <= cfg_d;
            mode_en_q    <= seq_ctrl_q[SEQ_EN_BIT];
            mode_roll_q  <= rolling;
            mode_trig_q  <= seq_ctrl_q[TRIGGERED_BIT];
            mode_slave_q <= seq_ctrl_q[SLAVE_BIT];
        end
    end

    assign active_cfg_o       = cfg_q;
    assign seq_enable_o       = mode_en_q;
    assign rolling_shutter_o  = mode_roll_q;
    assign triggered_mode_o   = mode_trig_q;
    assign slave_mode_o       = mode_slave_q;
    assign blank_frame_o      = blank_q;
    assign training_pattern_o = blank_q;
    assign image_enable_o     = ~blank_q;
    assign artifact_frame_o   = artf_cnt_q != 4'h0;

endmodule

// >>> rtl/shadow_active_reg.sv
`timescale 1ns/100ps
module shadow_active_reg
    import fsync_pkg::*;
#(
    parameter int               WIDTH = DATA_W,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             wr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic             frame_start_i,
    input  wire logic             sync_en_i,
    output logic      [WIDTH-1:0] shadow_o,
    output logic      [WIDTH-1:0] active_o,
    output logic                  update_o
);
    initial begin
        if (WIDTH < 1) $error("shadow_active_reg: WIDTH must be positive");
    end

    logic [WIDTH-1:0] shadow_q;
    logic [WIDTH-1:0] active_q;
    logic             transfer;

    assign transfer = frame_start_i & sync_en_i;
    assign update_o = transfer & (shadow_q != active_q);
    assign shadow_o = shadow_q;
    assign active_o = active_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            shadow_q <= RESET;
            active_q <= RESET;
        end else begin
            if (wr_i) shadow_q <= wr_data_i;
            if (transfer) active_q <= shadow_q;
        end
    end

endmodule

// >>> testbench/cfg_host_model.sv
`timescale 1ns/100ps
module cfg_host_model
    import fsync_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    initial {sck_o, cs_n_o, mosi_o} = 3'b010;
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
        logic [CMD_BITS-1:0] f;
        f = {a, w, d};
        q = '0;
        @(posedge ref_clk_i) cs_n_o <= 1'b0;
        for (int i = CMD_BITS - 1; i >= 0; i--) begin
            // Undriven data phase of a read toggles so a stale bit is never mistaken
            @(posedge ref_clk_i) mosi_o <= (i < DATA_W && !w) ? ~mosi_o : f[i];
            repeat (2) @(posedge ref_clk_i);
            @(posedge ref_clk_i) sck_o <= 1'b1;
            if (i < DATA_W) q[i] = miso_i & miso_oe_i;
            repeat (3) @(posedge ref_clk_i);
            @(posedge ref_clk_i) sck_o <= 1'b0;
        end
        @(posedge ref_clk_i) cs_n_o <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask
endmodule

// >>> testbench/frame_sync_config_update_properties.sv
`timescale 1ns/100ps
module fsync_checker
    import fsync_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        frame_start_i,
    input wire logic        rolling_shutter_o,
    input wire active_cfg_t active_cfg_o,
    input wire logic        blank_frame_o,
    input wire logic        training_pattern_o,
    input wire logic        image_enable_o
);
    logic [2:0] fs_q;
    logic [2:0] up_q;
    always_ff @(posedge ref_clk_i) begin
        fs_q <= {fs_q[1:0], frame_start_i};
        up_q <= {up_q[1:0], rst_n_i};
    end
    // Reset values land just after release, so judge only settled history
    wire ok   = &up_q;
    wire late = |fs_q[2:1];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet; !frame_start_i[*3]; endsequence
    property p_hold; ok ##0 s_quiet |=> $stable(active_cfg_o); endproperty
    property p_roi; ok && $changed(active_cfg_o.roi_select) |-> late; endproperty
    property p_gain; ok && $changed(active_cfg_o.gain) |-> late; endproperty
    property p_expo; ok && $changed(active_cfg_o.exposure) |-> late; endproperty
    property p_blank_edge; ok && $changed(blank_frame_o) |-> fs_q[0]; endproperty
    property p_blank_roll; $rose(blank_frame_o) |-> rolling_shutter_o; endproperty
    property p_train; training_pattern_o == blank_frame_o; endproperty
    property p_image; image_enable_o != blank_frame_o; endproperty
    a_hold: assert property (p_hold) else $error("config moved mid frame");
    a_roi: assert property (p_roi) else $error("window moved off frame start");
    a_gain: assert property (p_gain) else $error("gain moved off frame start");
    a_expo: assert property (p_expo) else $error("exposure moved off frame start");
    a_blank_edge: assert property (p_blank_edge) else $error("blank moved off frame start");
    a_blank_roll: assert property (p_blank_roll) else $error("blank in global mode");
    a_train: assert property (p_train) else $error("training differs from blank");
    a_image: assert property (p_image) else $error("image not suppressed");
endmodule
bind frame_sync_config_update fsync_checker fsync_checker_i (.*);

// >>> testbench/frame_sync_config_update_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module frame_sync_config_update_test
    import fsync_pkg::*;
;
    logic              ref_clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              frame_start_i = 1'b0;
    logic              sck, cs_n, mosi, miso, miso_oe, blank, train, img, art;
    logic [DATA_W-1:0] q;
    wire  [3:0]        mode;
    active_cfg_t       cfg;
    int                bad_count = 0;
    int                check_count = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    frame_sync_config_update #(.ARTIFACT_FRAMES(2)) frame_sync_config_update_i (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .frame_start_i(frame_start_i), .seq_enable_o(mode[0]),
        .rolling_shutter_o(mode[1]), .triggered_mode_o(mode[2]), .slave_mode_o(mode[3]), .active_cfg_o(cfg),
        .blank_frame_o(blank), .training_pattern_o(train), .image_enable_o(img), .artifact_frame_o(art));
    cfg_host_model cfg_host_model_i (.ref_clk_i(ref_clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
        .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        cfg_host_model_i.xfer(a, 1'b1, d, q);
    endtask
    task automatic fr(input int n);
        repeat (n) begin
            @(posedge ref_clk_i) frame_start_i <= 1'b1;
            @(posedge ref_clk_i) frame_start_i <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask
    task automatic t_reset;
        cfg_host_model_i.xfer(FREEZE_CTRL_ADDR, 1'b0, '0, q);
        `CHK(q, FREEZE_CTRL_RST)
        `CHK({cfg.roi_select, cfg.black_lines}, {ROI_SELECT_RST[7:0], BLACK_LINES_RST})
        `CHK({blank, img}, 2'b01)
        $display("reset test done");
    endtask
    task automatic t_rolling;
        wr(SEQ_CTRL_ADDR, 16'h0002);
        wr(SEQ_CTRL_ADDR, 16'h0003);
        wr(BLACK_LINES_ADDR, 16'h0010);
        `CHK(cfg.black_lines, BLACK_LINES_RST)
        fr(1);
        `CHK({cfg.black_lines, blank, train, img}, {16'h0010, 3'b110})
        fr(1);
        `CHK(blank, 1'b0)
        wr(FREEZE_CTRL_ADDR, 16'h013F);
        wr(ROI_SELECT_ADDR, 16'h0001);
        wr(SEQ_CTRL_ADDR, 16'h0083);
        `CHK(cfg.subsample, 1'b0)
        fr(1);
        `CHK({blank, cfg.subsample}, 2'b01)
        wr(ROI_SELECT_ADDR, 16'h0004);
        fr(1);
        `CHK({blank, cfg.roi_select}, 9'h104)
        fr(1);
        $display("rolling test done");
    endtask
    task automatic t_freeze;
        wr(FREEZE_CTRL_ADDR, 16'h002B);
        wr(GAIN_ADDR, 16'h0005);
        fr(1);
        wr(DUMMY_LINES_ADDR, 16'h0003);
        fr(1);
        `CHK({cfg.gain, cfg.dummy_lines}, 32'h0)
        wr(FREEZE_CTRL_ADDR, 16'h003F);
        fr(1);
        `CHK({cfg.gain, cfg.dummy_lines}, 32'h0005_0003)
        wr(GAIN_ADDR, 16'h2007);
        wr(EXPO_FIRST_ADDR, 16'h0033);
        fr(1);
        `CHK({cfg.gain, cfg.exposure[15:0]}, 32'h0005_0000)
        fr(1);
        `CHK({cfg.gain, cfg.exposure[15:0]}, 32'h2007_0033)
        wr(SEQ_CTRL_ADDR, 16'h0210);
        wr(EXPO_FIRST_ADDR, 16'h0044);
        fr(1);
        `CHK({mode, cfg.exposure[15:0]}, 20'h4_0044)
        $display("freeze test done");
    endtask
    task automatic t_transient;
        wr(BLK_LEVEL_FIRST, 16'h0001);
        fr(1);
        `CHK(art, 1'b1)
        fr(2);
        `CHK(art, 1'b0)
        wr(SYNC_CODE_FIRST, 16'h0001);
        `CHK(art, 1'b1)
        $display("transient test done");
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_reset();
        t_rolling();
        t_freeze();
        t_transient();
        report_and_stop();
    end
    initial begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
endmodule
